// >>> hw/opcg_top.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module opcg_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [W-1:0]      in_data,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [W-1:0]           out_data,
	output logic [$clog2(D):0]     count
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign in_ready  = cnt_q != (AW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rp_q];
	assign count     = cnt_q;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_q + AW'(push);
			rp_q  <= rp_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Memory-space window: PCI memory cycle at processor address plus window offset.
// - I/O window, contiguous layout: I/O cycle at address plus offset, unchanged.
// - I/O window, spread layout: offset applied, then spread remapping.
// - Pointer register write only stores; no PCI cycle.
// - Data register access with enabled pointer becomes a configuration cycle.
// - Bad pointer or bad access width falls back to a plain I/O cycle.
// - Window 3 resets to I/O at 0x80000000, pointer 0cf8, data 0cfc.
// - Register and function numbers drive the low configuration address bits.
// - Type 0 device number decodes to at most one IDSEL bit, AD31..AD11.
// - Bus number zero gives Type 0, nonzero gives Type 1.
// - Data write after priming issues a special cycle with write data.
// - Interrupt-ack read: one cycle, byte enables passed, vector returned.
// - Posted writes: 8-line FIFO, drain from 4 lines, stop at 1 or less.
// - Read-ahead size and threshold chosen per outbound window.
// - Half threshold: fill to size, resume at half or less.
// - Empty threshold: resume prefetch only when the read buffer is empty.
module opcg_top
	import opcg_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              pci_clk,
	input  wire logic              cpu_req,
	input  wire logic              cpu_we,
	input  wire logic [31:0]       cpu_addr,
	input  wire logic [3:0]        cpu_be,
	input  wire logic [31:0]       cpu_wdata,
	output logic                   cpu_ready,
	output logic                   cpu_ack,
	output logic [31:0]            cpu_rdata,
	input  wire logic [2:0][31:0]  outbound_window_decode,
	input  wire logic [2:0][15:0]  outbound_window_offset,
	input  wire logic [2:0][6:0]   outbound_window_attributes,
	input  wire logic              w3_load,
	input  wire logic [31:0]       outbound_window3_decode,
	input  wire logic [15:0]       outbound_window3_offset,
	input  wire logic [6:0]        outbound_window3_attributes,
	input  wire logic [31:0]       ad_i,
	output logic [31:0]            ad_o,
	output logic                   ad_oe,
	output logic [3:0]             cbe_o,
	output logic                   cbe_oe,
	output logic                   frame_n_o,
	output logic                   frame_oe,
	output logic                   irdy_n_o,
	output logic                   irdy_oe,
	input  wire logic              trdy_n_i,
	input  wire logic              devsel_n_i
);
	function automatic logic be_ok(input logic [3:0] b);
		case (b)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_ok = 1'b1;
			default: be_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [20:0] idsel(input logic [4:0] d);
		idsel = '0;
		if (d == 5'h00) begin
			idsel[20] = 1'b1;
		end else if (d >= 5'h0b && d <= 5'h1e) begin
			idsel[d - 5'h0b] = 1'b1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Window 3 and pointer registers
	logic [31:0] w3d_q;
	logic [15:0] w3o_q;
	logic [6:0]  w3a_q;
	logic        w3m_q;
	logic [31:0] ptr_q;
	logic [31:0] wdc [4];
	logic [15:0] wof [4];
	logic [6:0]  wat [4];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			w3d_q <= {W3_LO, W3_HI};
			w3o_q <= W3_OF;
			w3a_q <= W3_AT;
			w3m_q <= 1'b0;
		end else if (w3_load) begin
			w3d_q <= outbound_window3_decode;
			w3o_q <= outbound_window3_offset;
			w3a_q <= outbound_window3_attributes;
			w3m_q <= 1'b1;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_win
		assign wdc[g] = outbound_window_decode[g];
		assign wof[g] = outbound_window_offset[g];
		assign wat[g] = outbound_window_attributes[g];
	end
	assign wdc[3] = w3d_q;
	assign wof[3] = w3o_q;
	assign wat[3] = w3a_q;

	////////////////////////////////////////////////////////////////////////////
	// Processor address decode
	logic        hit, w3, iack, isp, isd, cfg, spc, posted, loc, miss;
	logic [6:0]  at;
	logic [31:0] ta, pa, xa;
	logic [3:0]  cmd;

	always_comb begin
		hit = 1'b0;
		w3  = 1'b0;
		at  = '0;
		ta  = cpu_addr;
		for (int i = 3; i >= 0; i--) begin
			if (wat[i][A_EN] && cpu_addr[31:16] >= wdc[i][31:16]
			    && cpu_addr[31:16] <= wdc[i][15:0]) begin
				hit = 1'b1;
				w3  = i == 3;
				at  = wat[i];
				ta  = cpu_addr + {wof[i], 16'h0000};
			end
		end
		pa   = (at[A_MEM] || !at[A_IOM]) ? ta : {5'h00, ta[31:12], ta[6:0]};
		iack = cpu_addr == IACK_ADR && !cpu_we;
		isp  = hit && w3 && !at[A_MEM] && pa[31:2] == PTR_OFS[31:2] && be_ok(cpu_be);
		isd  = hit && w3 && !at[A_MEM] && pa[31:2] == DAT_OFS[31:2] && be_ok(cpu_be);
		cfg  = isd && ptr_q[31];
		spc  = cfg && cpu_we && ptr_q == SPC_VAL;
		xa   = pa;
		cmd  = at[A_MEM] ? (cpu_we ? C_MW : C_MR) : (cpu_we ? C_IOW : C_IOR);
		if (iack) begin
			cmd = C_IACK;
			xa  = cpu_addr;
		end else if (spc) begin
			cmd = C_SPC;
		end else if (cfg) begin
			cmd = cpu_we ? C_CFW : C_CFR;
			xa  = ptr_q[23:16] == 8'h00 ? {idsel(ptr_q[15:11]), ptr_q[10:2], 2'b00}
			                            : {8'h00, ptr_q[23:2], 2'b01};
		end
		posted = hit && cpu_we && at[A_MEM] && !iack;
		loc    = isp;
		miss   = !hit && !iack;
	end

	////////////////////////////////////////////////////////////////////////////
	// Posting FIFO and processor handshake
	opcg_cst_t        cst_q;
	logic             f_in_rdy, f_in_v, fv, issue, accept, drain_q, flush;
	logic [FW-1:0]    fin, fo;
	logic [3:0]       f_cnt;
	logic [FW-1:0]    xq;
	logic             rtg_q, atg_q, busy_q, np_q, done_np, ack_e;
	logic [2:0]       as_q;
	logic [31:0]      rsp_q;

	assign f_in_v    = cst_q == CS_IDLE && cpu_req && !loc && !miss;
	assign cpu_ready = cst_q == CS_IDLE && (loc || miss || f_in_rdy);
	assign accept    = cpu_req && cpu_ready;
	assign fin       = {at[A_RA], at[A_VSZ+:2], at[A_THR], posted, cmd, cpu_be, xa, cpu_wdata};
	assign flush     = cst_q == CS_WAIT || !cpu_req;
	assign issue     = fv && !busy_q && (drain_q || !fo[F_PO]);
	assign ack_e     = as_q[1] ^ as_q[2];
	assign done_np   = ack_e && np_q;

	opcg_fifo #(.W(FW), .D(WP_DEPTH)) u_post (
		.clk       (ref_clk),
		.rst_n     (reset_n),
		.in_valid  (f_in_v),
		.in_ready  (f_in_rdy),
		.in_data   (fin),
		.out_valid (fv),
		.out_ready (issue),
		.out_data  (fo),
		.count     (f_cnt)
	);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_q <= PTR_RST;
		end else if (accept && isp && cpu_we) begin
			for (int b = 0; b < 4; b++) begin
				if (cpu_be[b]) begin
					ptr_q[8*b+:8] <= cpu_wdata[8*b+:8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			drain_q <= 1'b0;
		end else if (f_cnt >= WP_START || flush) begin
			drain_q <= 1'b1;
		end else if (f_cnt <= WP_STOP) begin
			drain_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cst_q     <= CS_IDLE;
			cpu_ack   <= 1'b0;
			cpu_rdata <= '0;
		end else begin
			cpu_ack <= 1'b0;
			case (cst_q)
				CS_IDLE: begin
					if (accept && (loc || miss || posted)) begin
						cpu_ack   <= 1'b1;
						cpu_rdata <= loc ? ptr_q : ONES;
					end else if (accept) begin
						cst_q <= CS_WAIT;
					end
				end
				CS_WAIT: begin
					if (done_np) begin
						cpu_ack   <= 1'b1;
						cpu_rdata <= rsp_q;
						cst_q     <= CS_IDLE;
					end
				end
				default: cst_q <= CS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xq     <= '0;
			rtg_q  <= 1'b0;
			busy_q <= 1'b0;
			np_q   <= 1'b0;
			as_q   <= '0;
		end else begin
			as_q <= {as_q[1:0], atg_q};
			if (issue) begin
				xq     <= fo;
				rtg_q  <= ~rtg_q;
				busy_q <= 1'b1;
				np_q   <= !fo[F_PO];
			end else if (ack_e) begin
				busy_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// PCI domain: reset, request crossing, cycle engine
	logic [1:0]  prs_q;
	logic [2:0]  rs_q;
	logic        prst_n, req_e, pend_q, pf_q, cwr_q, ra_hit, pf_go, fin_c, pop;
	opcg_pst_t   pst_q;
	logic [3:0]  ccm_q, cbq_q;
	logic [31:0] car_q, cdt_q;
	logic [3:0]  cra_q;
	logic [2:0]  wt_q;
	logic        ra_q, rth_q, pfo_q;
	logic [31:0] rh_q, rn_q;
	logic [3:0]  rln_q, lvl_q;
	logic [2:0]  rwp_q, rrp_q;
	logic [31:0] rb_q [8];

	assign prst_n = prs_q[1];
	assign req_e  = rs_q[1] ^ rs_q[2];
	assign ra_hit = pend_q && xq[F_CM+:4] == C_MR && ra_q && xq[F_AD+:32] == rh_q
	                && lvl_q != 4'h0;
	assign pf_go  = ra_q && pfo_q && lvl_q < rln_q && !pend_q;
	assign pop    = pst_q == PS_IDLE && ra_hit;
	assign fin_c  = pst_q == PS_DATA && ((!trdy_n_i && !devsel_n_i)
	                || (devsel_n_i && wt_q == DS_WAIT));

	always_ff @(posedge pci_clk or negedge reset_n) begin
		if (!reset_n) begin
			prs_q <= '0;
		end else begin
			prs_q <= {prs_q[0], 1'b1};
		end
	end

	always_ff @(posedge pci_clk or negedge prst_n) begin
		if (!prst_n) begin
			rs_q   <= '0;
			pend_q <= 1'b0;
			atg_q  <= 1'b0;
			rsp_q  <= '0;
		end else begin
			rs_q <= {rs_q[1:0], rtg_q};
			if (req_e) begin
				pend_q <= 1'b1;
			end else if (pop) begin
				pend_q <= 1'b0;
				rsp_q  <= rb_q[rrp_q];
				atg_q  <= ~atg_q;
			end else if (fin_c && !pf_q) begin
				pend_q <= 1'b0;
				rsp_q  <= trdy_n_i ? ONES : ad_i;
				atg_q  <= ~atg_q;
			end
		end
	end

	always_ff @(posedge pci_clk or negedge prst_n) begin
		if (!prst_n) begin
			pst_q     <= PS_IDLE;
			pf_q      <= 1'b0;
			cwr_q     <= 1'b0;
			ccm_q     <= C_IACK;
			cbq_q     <= '0;
			car_q     <= '0;
			cdt_q     <= '0;
			cra_q     <= '0;
			wt_q      <= '0;
			ad_o      <= '0;
			ad_oe     <= 1'b0;
			cbe_o     <= '0;
			cbe_oe    <= 1'b0;
			frame_n_o <= 1'b1;
			frame_oe  <= 1'b0;
			irdy_n_o  <= 1'b1;
			irdy_oe   <= 1'b0;
		end else begin
			case (pst_q)
				PS_IDLE: begin
					if ((pend_q && !ra_hit) || pf_go) begin
						pf_q      <= !pend_q;
						ccm_q     <= pend_q ? xq[F_CM+:4] : C_MR;
						cbq_q     <= pend_q ? xq[F_BE+:4] : BE_ALL;
						car_q     <= pend_q ? xq[F_AD+:32] : rn_q;
						cdt_q     <= xq[31:0];
						cra_q     <= xq[F_TH+:4];
						cwr_q     <= pend_q && xq[F_CM];
						ad_o      <= pend_q ? xq[F_AD+:32] : rn_q;
						cbe_o     <= pend_q ? xq[F_CM+:4] : C_MR;
						ad_oe     <= 1'b1;
						cbe_oe    <= 1'b1;
						frame_n_o <= 1'b0;
						frame_oe  <= 1'b1;
						irdy_oe   <= 1'b1;
						pst_q     <= PS_ADDR;
					end
				end
				PS_ADDR: begin
					frame_n_o <= 1'b1;
					irdy_n_o  <= 1'b0;
					cbe_o     <= cbq_q;
					ad_o      <= cdt_q;
					ad_oe     <= cwr_q;
					wt_q      <= '0;
					pst_q     <= PS_DATA;
				end
				PS_DATA: begin
					wt_q <= wt_q + 3'(devsel_n_i);
					if (fin_c) begin
						irdy_n_o <= 1'b1;
						ad_oe    <= 1'b0;
						cbe_oe   <= 1'b0;
						pst_q    <= PS_TURN;
					end
				end
				PS_TURN: begin
					frame_oe <= 1'b0;
					irdy_oe  <= 1'b0;
					pst_q    <= PS_IDLE;
				end
				default: pst_q <= PS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read-ahead buffer and thresholds
	always_ff @(posedge pci_clk) begin
		if (fin_c && pf_q) begin
			rb_q[rwp_q] <= ad_i;
		end
	end

	always_ff @(posedge pci_clk or negedge prst_n) begin
		if (!prst_n) begin
			ra_q  <= 1'b0;
			rth_q <= 1'b0;
			pfo_q <= 1'b0;
			rh_q  <= '0;
			rn_q  <= '0;
			rln_q <= RA_LINES;
			lvl_q <= '0;
			rwp_q <= '0;
			rrp_q <= '0;
		end else if (pst_q == PS_IDLE && pend_q && !ra_hit) begin
			ra_q  <= 1'b0;
			lvl_q <= '0;
		end else if (fin_c && !pf_q && ccm_q == C_MR) begin
			ra_q  <= cra_q[3] && !trdy_n_i;
			rth_q <= cra_q[0];
			rln_q <= 4'(RA_LINES << cra_q[2:1]);
			rh_q  <= car_q + LINE_B;
			rn_q  <= car_q + LINE_B;
			pfo_q <= 1'b1;
			lvl_q <= '0;
			rwp_q <= '0;
			rrp_q <= '0;
		end else if (fin_c && pf_q) begin
			ra_q  <= !trdy_n_i;
			rwp_q <= rwp_q + 3'h1;
			rn_q  <= rn_q + LINE_B;
			lvl_q <= lvl_q + 4'h1;
			if (lvl_q + 4'h1 == rln_q) begin
				pfo_q <= 1'b0;
			end
		end else if (pop) begin
			rrp_q <= rrp_q + 3'h1;
			rh_q  <= rh_q + LINE_B;
			lvl_q <= lvl_q - 4'h1;
			if (rth_q ? lvl_q == 4'h1 : lvl_q - 4'h1 <= (rln_q >> 1)) begin
				pfo_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	mem_cycle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && at[A_MEM] && !iack |-> (cmd == C_MW || cmd == C_MR) && xa == ta)
		else $error("memory window did not give a memory cycle");
	cont_io_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && !at[A_MEM] && !at[A_IOM] && !cfg && !iack |-> xa == ta)
		else $error("contiguous I/O address wrong");
	spread_io_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && !at[A_MEM] && at[A_IOM] && !cfg && !iack
		|-> xa[6:0] == cpu_addr[6:0] && xa[26:7] == ta[31:12])
		else $error("spread I/O remap wrong");
	ptr_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		accept && isp && cpu_we |-> !f_in_v ##1 cpu_ack ##0 f_cnt <= $past(f_cnt))
		else $error("pointer write reached the PCI queue");
	w3_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!w3m_q |-> w3d_q[31:16] == W3_LO && w3o_q == W3_OF && !w3a_q[A_MEM])
		else $error("window 3 lost its reset map");
	bad_width_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && w3 && !at[A_MEM] && pa[31:3] == PTR_OFS[31:3] && !be_ok(cpu_be)
		|-> cmd == C_IOR || cmd == C_IOW)
		else $error("bad width not sent as I/O");
	idsel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && cfg && !spc && ptr_q[23:16] == 8'h00
		|-> $onehot0(xa[31:11]) && xa[31] == (ptr_q[15:11] == 5'h00)
		&& xa[10:2] == ptr_q[10:2])
		else $error("IDSEL decode wrong");
	type1_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && cfg && ptr_q[23:16] != 8'h00 |-> xa[1:0] == 2'b01)
		else $error("nonzero bus not Type 1");
	iack_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && f_in_rdy && iack |-> cmd == C_IACK && fin[F_BE+:4] == cpu_be
		##1 cst_q == CS_WAIT)
		else $error("interrupt acknowledge not queued");
	drain_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(drain_q) |-> $past(f_cnt) <= WP_STOP && f_cnt < WP_START)
		else $error("posting drain stopped early");
	pf_stop_a: assert property (@(posedge pci_clk) disable iff (!prst_n)
		ra_q && lvl_q == rln_q |-> !pfo_q && !pf_go)
		else $error("prefetch past virtual size");
	pf_empty_a: assert property (@(posedge pci_clk) disable iff (!prst_n)
		ra_q && rth_q && $rose(pfo_q) |-> lvl_q == 4'h0)
		else $error("empty threshold resumed early");
	spc_c: cover property (@(posedge ref_clk) disable iff (!reset_n) f_in_v && spc);
	t1_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
		f_in_v && cfg && ptr_q[23:16] != 8'h00);
	resume_c: cover property (@(posedge pci_clk) disable iff (!prst_n)
		ra_q && $rose(pfo_q) && lvl_q != 4'h0);
endmodule

`default_nettype wire

// >>> hw/opcg_pkg.sv
`default_nettype none

package opcg_pkg;
	localparam logic [3:0]  C_IACK   = 4'h0;
	localparam logic [3:0]  C_SPC    = 4'h1;
	localparam logic [3:0]  C_IOR    = 4'h2;
	localparam logic [3:0]  C_IOW    = 4'h3;
	localparam logic [3:0]  C_MR     = 4'h6;
	localparam logic [3:0]  C_MW     = 4'h7;
	localparam logic [3:0]  C_CFR    = 4'ha;
	localparam logic [3:0]  C_CFW    = 4'hb;
	localparam logic [31:0] PTR_OFS  = 32'h0000_0cf8;
	localparam logic [31:0] DAT_OFS  = 32'h0000_0cfc;
	localparam logic [31:0] IACK_ADR = 32'hfef8_0030;
	localparam logic [31:0] SPC_VAL  = 32'h8000_ff00;
	localparam logic [31:0] PTR_RST  = 32'h0000_0000;
	localparam logic [31:0] ONES     = 32'hffff_ffff;
	localparam logic [31:0] LINE_B   = 32'h0000_0004;
	localparam logic [15:0] W3_LO    = 16'h8000;
	localparam logic [15:0] W3_HI    = 16'hbfff;
	localparam logic [15:0] W3_OF    = 16'h8000;
	localparam logic [6:0]  W3_AT    = 7'h01;
	localparam int          A_EN     = 0;
	localparam int          A_MEM    = 1;
	localparam int          A_IOM    = 2;
	localparam int          A_RA     = 3;
	localparam int          A_VSZ    = 4;
	localparam int          A_THR    = 6;
	localparam int          WP_DEPTH = 8;
	localparam logic [3:0]  WP_START = 4'h4;
	localparam logic [3:0]  WP_STOP  = 4'h1;
	localparam logic [3:0]  RA_LINES = 4'h2;
	localparam logic [3:0]  BE_ALL   = 4'hf;
	localparam logic [2:0]  DS_WAIT  = 3'h5;
	localparam int          FW       = 77;
	localparam int          F_RA     = 76;
	localparam int          F_VS     = 74;
	localparam int          F_TH     = 73;
	localparam int          F_PO     = 72;
	localparam int          F_CM     = 68;
	localparam int          F_BE     = 64;
	localparam int          F_AD     = 32;

	typedef enum logic {CS_IDLE, CS_WAIT} opcg_cst_t;
	typedef enum logic [1:0] {PS_IDLE, PS_ADDR, PS_DATA, PS_TURN} opcg_pst_t;
endpackage

`default_nettype wire

// >>> bench/opcg_pci_target.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module opcg_pci_target
	import opcg_pkg::*;
#(
	parameter logic [31:0] VEC = 32'h0000_00a7
) (
	input  wire logic        pci_clk,
	input  wire logic        reset_n,
	input  wire logic [31:0] ad_o,
	input  wire logic [3:0]  cbe_o,
	input  wire logic        frame_n_o,
	input  wire logic        frame_oe,
	input  wire logic        irdy_n_o,
	input  wire logic        irdy_oe,
	input  wire logic        cbe_oe,
	input  wire logic        quiet,
	input  wire logic [2:0]  wait_n,
	output logic [31:0]      ad_t,
	output logic             trdy_n_i,
	output logic             devsel_n_i,
	output logic [31:0]      log_addr,
	output logic [3:0]       log_cmd,
	output logic [31:0]      log_data,
	output logic [3:0]       log_be,
	output int               cyc_cnt
);
	logic       busy_q;
	logic [2:0] wcnt_q;

	// Single data phase target with optional wait states
	always_ff @(posedge pci_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			wcnt_q <= 3'h0;
			trdy_n_i <= 1'b1;
			devsel_n_i <= 1'b1;
			ad_t <= 32'h0;
			cyc_cnt <= 0;
		end else if (!trdy_n_i) begin
			// Released bus shows the inverse of the last value
			trdy_n_i <= 1'b1;
			devsel_n_i <= 1'b1;
			busy_q <= 1'b0;
			ad_t <= ~ad_t;
		end else if (!busy_q) begin
			if (frame_oe && !frame_n_o) begin
				busy_q <= 1'b1;
				wcnt_q <= 3'h0;
				log_addr <= ad_o;
				log_cmd <= cbe_o;
			end
		end else if (quiet) begin
			// Silent target: wait for the master to give up
			busy_q <= !irdy_n_o;
		end else if (irdy_oe && !irdy_n_o) begin
			devsel_n_i <= 1'b0;
			if (wcnt_q < wait_n) begin
				wcnt_q <= wcnt_q + 3'h1;
			end else begin
				trdy_n_i <= 1'b0;
				log_data <= ad_o;
				log_be <= cbe_o & {4{cbe_oe}};
				cyc_cnt <= cyc_cnt + 1;
				ad_t <= (log_cmd == C_IACK) ? VEC : log_addr ^ 32'h5a5a_0000;
			end
		end
	end
endmodule

`default_nettype wire

// >>> bench/opcg_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module opcg_top_tb
	import opcg_pkg::*;
;
	localparam logic [31:0] VEC   = 32'h0000_00a7;
	localparam logic [31:0] PTR_A = 32'h8000_0cf8;
	localparam logic [31:0] DAT_A = 32'h8000_0cfc;
	logic ref_clk = 0, pci_clk = 0, reset_n = 0, cpu_req = 0, cpu_we = 0;
	logic [31:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, rd_q, ad_o, ad_t, ad_bus, log_addr;
	logic [31:0] log_data;
	logic [3:0]  cpu_be = 0, cbe_o, log_cmd, log_be;
	logic        cpu_ready, cpu_ack, ad_oe, cbe_oe, frame_n_o, frame_oe, irdy_n_o, irdy_oe;
	logic        trdy_n_i, devsel_n_i;
	logic [2:0]  wait_n = 0;
	logic        quiet = 0;
	logic [2:0][31:0] win_dec = {32'hf000_f0ff, 32'he000_e0ff, 32'hc000_cfff};
	logic [2:0][15:0] win_ofs = {16'h0100, 16'h0000, 16'h1000};
	logic [2:0][6:0]  win_att = {7'h01, 7'h05, 7'h07};
	int          cyc_cnt, num_errors = 0, checks_done = 0, tmo = 0;
	int          devs[5] = '{0, 5, 11, 30, 31};

	always #50 ref_clk = ~ref_clk;
	always begin
		#62 pci_clk = ~pci_clk;
		#63 pci_clk = ~pci_clk;
	end
	assign ad_bus = ad_oe ? ad_o : ad_t;

	opcg_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .pci_clk(pci_clk), .cpu_req(cpu_req),
		.cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_be(cpu_be), .cpu_wdata(cpu_wdata),
		.cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.outbound_window_decode(win_dec), .outbound_window_offset(win_ofs),
		.outbound_window_attributes(win_att), .w3_load(1'b0),
		.outbound_window3_decode(32'h0), .outbound_window3_offset(16'h0),
		.outbound_window3_attributes(7'h0), .ad_i(ad_bus), .ad_o(ad_o), .ad_oe(ad_oe),
		.cbe_o(cbe_o), .cbe_oe(cbe_oe), .frame_n_o(frame_n_o), .frame_oe(frame_oe),
		.irdy_n_o(irdy_n_o), .irdy_oe(irdy_oe), .trdy_n_i(trdy_n_i), .devsel_n_i(devsel_n_i));

	opcg_pci_target #(.VEC(VEC)) tgt (.pci_clk(pci_clk), .reset_n(reset_n), .ad_o(ad_bus),
		.cbe_o(cbe_o), .frame_n_o(frame_n_o), .frame_oe(frame_oe), .irdy_n_o(irdy_n_o),
		.irdy_oe(irdy_oe), .cbe_oe(cbe_oe), .quiet(quiet), .wait_n(wait_n), .ad_t(ad_t),
		.trdy_n_i(trdy_n_i),
		.devsel_n_i(devsel_n_i), .log_addr(log_addr), .log_cmd(log_cmd),
		.log_data(log_data), .log_be(log_be), .cyc_cnt(cyc_cnt));

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] idsel(input int d);
		if (d == 0) return 32'h8000_0000;
		if (d >= 11 && d <= 30) return 32'h1 << d;
		return 32'h0;
	endfunction

	// One processor access, held until taken, then wait for the answer
	task automatic access(input logic we, input logic [31:0] a, input logic [3:0] be,
			input logic [31:0] wd);
		int n;
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_be <= be;
		cpu_wdata <= wd;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cpu_ready !== 1'b1 && n < 3000);
		cpu_req <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cpu_ack !== 1'b1 && n < 3000);
		rd_q = cpu_rdata;
		if (n >= 3000) check(32'h0, 32'h1);
	endtask

	task automatic wait_pci(input int want);
		for (int n = 0; n < 600 && cyc_cnt < want; n++) @(posedge ref_clk);
	endtask

	// Access that must give exactly one PCI cycle of the given kind
	task automatic xfer(input logic we, input logic [31:0] a, input logic [3:0] be,
			input logic [31:0] wd, input logic [3:0] cmd, input logic [31:0] pa);
		int c0;
		c0 = cyc_cnt;
		access(we, a, be, wd);
		wait_pci(c0 + 1);
		check(32'(cyc_cnt), 32'(c0 + 1));
		check({28'h0, log_cmd}, {28'h0, cmd});
		check({28'h0, log_be}, {28'h0, be});
		if (cmd != C_SPC && cmd != C_IACK) check(log_addr, pa);
		if (we) check(log_data, wd);
		else check(rd_q, (cmd == C_IACK) ? VEC : pa ^ 32'h5a5a_0000);
	endtask

	always @(posedge ref_clk) begin
		tmo++;
		if (tmo == 20000) begin
			check(32'h0, 32'h1);
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int c0;
		logic [31:0] p;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		access(1'b0, PTR_A, BE_ALL, 32'h0);
		check(rd_q, PTR_RST);
		c0 = cyc_cnt;
		access(1'b1, PTR_A, BE_ALL, 32'h8000_5810);
		repeat (40) @(posedge ref_clk);
		access(1'b0, PTR_A, BE_ALL, 32'h0);
		check(rd_q, 32'h8000_5810);
		check(32'(cyc_cnt), 32'(c0));
		access(1'b0, 32'h4000_0000, BE_ALL, 32'h0);
		check(rd_q, ONES);
		$display("pointer test done");
		xfer(1'b0, 32'h8000_0010, BE_ALL, 32'h0, C_IOR, 32'h0000_0010);
		xfer(1'b1, 32'hf000_0010, 4'h3, 32'h0000_beef, C_IOW, 32'hf100_0010);
		xfer(1'b1, 32'he000_3004, BE_ALL, 32'h1111_2222, C_IOW, {5'h0, 20'he0003, 7'h04});
		xfer(1'b0, 32'hc000_1230, BE_ALL, 32'h0, C_MR, 32'hd000_1230);
		xfer(1'b1, 32'hc000_1240, BE_ALL, 32'hcafe_0001, C_MW, 32'hd000_1240);
		$display("window test done");
		foreach (devs[i]) begin
			p = 32'h8000_0310 | (32'(devs[i]) << 11);
			access(1'b1, PTR_A, BE_ALL, p);
			xfer(1'b0, DAT_A, BE_ALL, 32'h0, C_CFR, idsel(devs[i]) | 32'h0310);
			xfer(1'b1, DAT_A, BE_ALL, ~p, C_CFW, idsel(devs[i]) | 32'h0310);
		end
		access(1'b1, PTR_A, BE_ALL, 32'h8005_1a10);
		xfer(1'b0, DAT_A, BE_ALL, 32'h0, C_CFR, 32'h0005_1a11);
		xfer(1'b1, DAT_A, 4'h7, 32'h0077_7777, C_IOW, 32'h0000_0cfc);
		access(1'b1, PTR_A, BE_ALL, 32'h0000_5810);
		xfer(1'b0, DAT_A, BE_ALL, 32'h0, C_IOR, 32'h0000_0cfc);
		$display("config test done");
		access(1'b1, PTR_A, BE_ALL, SPC_VAL);
		xfer(1'b1, DAT_A, BE_ALL, 32'h1234_5678, C_SPC, 32'h0);
		xfer(1'b0, IACK_ADR, 4'h3, 32'h0, C_IACK, 32'h0);
		c0 = cyc_cnt;
		repeat (30) @(posedge ref_clk);
		check(32'(cyc_cnt), 32'(c0));
		$display("special test done");
		wait_n <= 3'h3;
		for (int i = 0; i < 8; i++) access(1'b1, 32'hc000_2000 + 32'(4 * i), BE_ALL, 32'(i));
		wait_pci(c0 + 8);
		check(32'(cyc_cnt), 32'(c0 + 8));
		check(log_addr, 32'hd000_201c);
		check(log_data, 32'h7);
		wait_n <= 3'h0;
		$display("posting test done");
		for (int t = 0; t < 2; t++) begin
			win_att[0] <= (t == 0) ? 7'h0b : 7'h4b;
			for (int i = 0; i < 5; i++) begin
				p = 32'hc000_3000 + 32'(t * 256 + 4 * i);
				access(1'b0, p, BE_ALL, 32'h0);
				check(rd_q, (p + 32'h1000_0000) ^ 32'h5a5a_0000);
			end
		end
		$display("read-ahead test done");
		quiet <= 1'b1;
		access(1'b0, 32'h8000_0040, BE_ALL, 32'h0);
		check(rd_q, ONES);
		quiet <= 1'b0;
		$display("abort test done");
		summarize();
	end
endmodule

`default_nettype wire
